/* File: dual_adc_regs_defines.svh */
`ifndef DUAL_ADC_REGS_DEFINES_SVH
`define DUAL_ADC_REGS_DEFINES_SVH

// Four-bit register addresses carried by the command byte.
`define ADDR_COMMAND_STATUS 4'h0
`define ADDR_MODE 4'h1
`define ADDR_MAIN_CTRL 4'h2
`define ADDR_AUX_CTRL 4'h3
`define ADDR_FILTER 4'h4
`define ADDR_MAIN_RESULT 4'h5
`define ADDR_AUX_RESULT 4'h6
`define ADDR_PORT_CTRL 4'h7
`define ADDR_MAIN_OFFSET 4'h8
`define ADDR_AUX_OFFSET 4'h9
`define ADDR_MAIN_GAIN 4'ha
`define ADDR_AUX_GAIN 4'hb
`define ADDR_TEST_ONE 4'hc
`define ADDR_TEST_TWO 4'hd
`define ADDR_UNDEFINED 4'he
`define ADDR_IDENT 4'hf

// Command byte fields.
`define CMD_WRITE_ENABLE_N_BIT 7
`define CMD_READ_BIT 6
`define CMD_ADDR_MSB 3
`define CMD_ADDR_LSB 0
`define CMD_LENGTH 5'd8

// Power-on values.
`define RST_MODE 8'h00
`define RST_MAIN_CTRL 8'h07
`define RST_AUX_CTRL 8'h01
`define RST_PORT_CTRL 16'h0000
`define RST_FILTER 8'h45
`define RST_MAIN_RESULT 24'h000000
`define RST_AUX_RESULT 16'h0000
`define RST_MAIN_OFFSET 24'h800000
`define RST_AUX_OFFSET 16'h8000
`define RST_TEST 16'h0000

// Bit of the port control word that always reads as zero.
`define PORT_CTRL_RESERVED_MASK 16'h2000

// Access lengths in serial clocks.
`define LEN_BYTE 5'd8
`define LEN_HALF 5'd16
`define LEN_FULL 5'd24

// Consecutive high data bits that put the whole bank back to power-on state.
`define ONES_RESET_COUNT 6'd32

// Number of main input channel pairs with their own coefficients.
`define MAIN_PAIR_COUNT 3

`endif

/* File: dual_adc_regs_pkg.sv */
package dual_adc_regs_pkg;

   typedef struct packed {
      logic mainConverterOn;
      logic resultLengthSelect;
      logic [1:0] mainPairSelect;
      logic mainUnipolar;
      logic [2:0] mainSpan;
   } main_ctrl_t;

   typedef struct packed {
      logic auxConverterOn;
      logic [2:0] auxInputSelect;
      logic auxUnipolar;
      logic [1:0] auxReserved;
      logic auxSpanSelect;
   } aux_ctrl_t;

   typedef struct packed {
      logic lowSideSwitchTwo;
      logic lowSideSwitchOne;
      logic portReserved;
      logic openSensorCurrent;
      logic excitationTwoPin;
      logic excitationOnePin;
      logic excitationTwoOn;
      logic excitationOneOn;
      logic portPin4Direction;
      logic portPin3Direction;
      logic portPin2Enable;
      logic portPin1Enable;
      logic [3:0] portPinData;
   } port_ctrl_t;

   typedef enum logic {
      PHASE_COMMAND,
      PHASE_DATA
   } link_phase_t;

   typedef struct packed {
      logic selected;
      logic rise;
      logic fall;
      logic dataBit;
   } serial_event_t;

   typedef struct packed {
      logic [2:0] stageOne;
      logic [2:0] stageTwo;
      logic clkPrev;
   } sampler_state_t;

   typedef struct packed {
      link_phase_t phase;
      logic [4:0] bitCount;
      logic [4:0] dataWidth;
      logic isRead;
      logic [3:0] addr;
      logic [23:0] inShift;
      logic [23:0] outShift;
      logic [5:0] onesCount;
      logic [7:0] mode;
      main_ctrl_t mainCtrl;
      aux_ctrl_t auxCtrl;
      port_ctrl_t portCtrl;
      logic [7:0] filterWord;
      logic [23:0] mainResult;
      logic [15:0] auxResult;
      logic [2:0][23:0] mainOffset;
      logic [2:0][23:0] mainGain;
      logic [15:0] auxOffset;
      logic [15:0] auxGain;
      logic [15:0] testOne;
      logic [15:0] testTwo;
      logic [23:0] mainOffsetSel;
      logic [23:0] mainGainSel;
      logic dout;
      logic doutOeN;
   } bank_state_t;

endpackage

/* File: serial_pin_sampler.sv */
`timescale 1ns/1ps
`include "dual_adc_regs_defines.svh"

// Brings the three serial pins into the ref_clk domain and marks clock edges.
module serial_pin_sampler
   import dual_adc_regs_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic chipSelectN,
   input wire logic serialClk,
   input wire logic serialDataIn,
   output serial_event_t events
);

   sampler_state_t s_q;
   sampler_state_t s_d;

   always_comb begin
      s_d = s_q;
      s_d.stageOne = {chipSelectN, serialClk, serialDataIn};
      s_d.stageTwo = s_q.stageOne;
      s_d.clkPrev = s_q.stageTwo[1];
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q <= '{stageOne: 3'h7, stageTwo: 3'h7, clkPrev: 1'b1};
      end else begin
         s_q <= s_d;
      end
   end

   // Edges are judged on the second stage only, never on the first.
   always_comb begin
      events.selected = ~s_q.stageTwo[2];
      events.rise = s_q.stageTwo[1] & ~s_q.clkPrev;
      events.fall = ~s_q.stageTwo[1] & s_q.clkPrev;
      events.dataBit = s_q.stageTwo[0];
   end

endmodule

/* File: dual_adc_register_bank.sv */
// Functional notes
// [R1] Main control byte, read/write, resets 07.
// [R2] Aux control byte, read/write, resets 01.
// [R3] Port control word, 16 bits, resets 0000.
// [R4] Filter word, read/write, resets 45.
// [R5] One filter word rates both converters.
// [R6] Main result read-only, 16 or 24 bits.
// [R7] Aux result read-only, 16 bits, resets 0000.
// [R8] Main offset coefficient 24 bits, resets 800000.
// [R9] Three main offsets, chosen by channel pair.
// [R10] Main gain coefficient, factory reset value.
// [R11] Three main gains, chosen by channel pair.
// [R12] Aux offset coefficient 16 bits, resets 8000.
// [R13] Aux gain 16 bits, factory low byte.
// [R14] Identification byte fixed, writes ignored.
// [R15] Host leaves test registers at zero.
// [R16] Each access starts with command byte.
// [R17] Four-bit address decodes the register map.
// [R18] Reset loads defaults and factory coefficients.
`timescale 1ns/1ps
`include "dual_adc_regs_defines.svh"

module dual_adc_register_bank
   import dual_adc_regs_pkg::*;
#(
   parameter logic [7:0] PART_IDENT = 8'h96, // Arbitrary identification value.
   parameter logic [23:0] MAIN_GAIN_FACTORY = 24'h500005,
   parameter logic [7:0] AUX_GAIN_FACTORY_LOW = 8'h00
)
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic chipSelectN,
   input wire logic serialClk,
   input wire logic serialDataIn,
   output logic serialDataOut,
   output logic serialDataOutOeN,
   input wire logic [7:0] statusByte,
   input wire logic mainResultValid,
   input wire logic [23:0] mainResultIn,
   input wire logic auxResultValid,
   input wire logic [15:0] auxResultIn,
   output logic [7:0] modeWord,
   output main_ctrl_t mainCtrl,
   output aux_ctrl_t auxCtrl,
   output port_ctrl_t portCtrl,
   output logic [7:0] updateRateWord,
   output logic [23:0] mainOffsetActive,
   output logic [23:0] mainGainActive,
   output logic [15:0] auxOffset,
   output logic [15:0] auxGain,
   output logic [15:0] testOne,
   output logic [15:0] testTwo
);

   // The aux gain power-on upper byte is fixed; only the lower byte varies per part.
   localparam logic [7:0] AUX_GAIN_FIXED_HIGH = 8'h59;

   serial_event_t ev;
   bank_state_t s_q;
   bank_state_t s_d;

   serial_pin_sampler sampler (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .chipSelectN(chipSelectN),
      .serialClk(serialClk),
      .serialDataIn(serialDataIn),
      .events(ev)
   );

   function automatic bank_state_t powerOnState();
      bank_state_t r;
      r = '0;
      r.phase = PHASE_COMMAND;
      r.doutOeN = 1'b1;
      r.mode = `RST_MODE;
      r.mainCtrl = `RST_MAIN_CTRL; // [R1]
      r.auxCtrl = `RST_AUX_CTRL; // [R2]
      r.portCtrl = `RST_PORT_CTRL; // [R3]
      r.filterWord = `RST_FILTER; // [R4]
      r.mainResult = `RST_MAIN_RESULT; // [R6]
      r.auxResult = `RST_AUX_RESULT; // [R7]
      for (int i = 0; i < `MAIN_PAIR_COUNT; i++) begin
         r.mainOffset[i] = `RST_MAIN_OFFSET; // [R8]
         r.mainGain[i] = MAIN_GAIN_FACTORY; // [R10]
      end
      r.auxOffset = `RST_AUX_OFFSET; // [R12]
      r.auxGain = {AUX_GAIN_FIXED_HIGH, AUX_GAIN_FACTORY_LOW}; // [R13]
      r.testOne = `RST_TEST;
      r.testTwo = `RST_TEST;
      r.mainOffsetSel = `RST_MAIN_OFFSET; // [R18]
      r.mainGainSel = MAIN_GAIN_FACTORY; // [R18]
      return r;
   endfunction

   // Pair code 3 has no coefficient set of its own and shares the third one.
   function automatic logic [1:0] pairIndex(input logic [1:0] pair);
      return (pair == 2'd3) ? 2'd2 : pair;
   endfunction

   function automatic logic [4:0] regWidth(input logic [3:0] addr, input logic longResult);
      logic [4:0] w;
      w = `LEN_BYTE;
      case (addr) // [R17]
         `ADDR_MAIN_RESULT: w = longResult ? `LEN_FULL : `LEN_HALF; // [R6]
         `ADDR_AUX_RESULT: w = `LEN_HALF; // [R7]
         `ADDR_PORT_CTRL: w = `LEN_HALF;
         `ADDR_MAIN_OFFSET: w = `LEN_FULL;
         `ADDR_MAIN_GAIN: w = `LEN_FULL;
         `ADDR_AUX_OFFSET: w = `LEN_HALF;
         `ADDR_AUX_GAIN: w = `LEN_HALF;
         `ADDR_TEST_ONE: w = `LEN_HALF;
         `ADDR_TEST_TWO: w = `LEN_HALF;
         default: w = `LEN_BYTE;
      endcase
      return w;
   endfunction

   // Readback value placed so that its first bit sits in bit 23.
   function automatic logic [23:0] readAligned(input bank_state_t st, input logic [3:0] addr,
                                               input logic [7:0] status);
      logic [23:0] v;
      logic [1:0] p;
      v = '0;
      p = pairIndex(st.mainCtrl.mainPairSelect);
      case (addr) // [R17]
         `ADDR_COMMAND_STATUS: v = {status, 16'h0000};
         `ADDR_MODE: v = {st.mode, 16'h0000};
         `ADDR_MAIN_CTRL: v = {st.mainCtrl, 16'h0000};
         `ADDR_AUX_CTRL: v = {st.auxCtrl, 16'h0000};
         `ADDR_FILTER: v = {st.filterWord, 16'h0000};
         `ADDR_MAIN_RESULT: v = st.mainResult; // [R6]
         `ADDR_AUX_RESULT: v = {st.auxResult, 8'h00}; // [R7]
         `ADDR_PORT_CTRL: v = {st.portCtrl, 8'h00};
         `ADDR_MAIN_OFFSET: v = st.mainOffset[p]; // [R9]
         `ADDR_MAIN_GAIN: v = st.mainGain[p]; // [R11]
         `ADDR_AUX_OFFSET: v = {st.auxOffset, 8'h00};
         `ADDR_AUX_GAIN: v = {st.auxGain, 8'h00};
         `ADDR_TEST_ONE: v = {st.testOne, 8'h00};
         `ADDR_TEST_TWO: v = {st.testTwo, 8'h00};
         `ADDR_IDENT: v = {PART_IDENT, 16'h0000}; // [R14]
         default: v = '0;
      endcase
      return v;
   endfunction

   // Stores a completed write; read-only and undefined addresses drop the data.
   function automatic bank_state_t commitWrite(input bank_state_t st, input logic [23:0] val);
      bank_state_t r;
      logic [1:0] p;
      r = st;
      p = pairIndex(st.mainCtrl.mainPairSelect);
      case (st.addr) // [R17]
         `ADDR_MODE: r.mode = val[7:0];
         `ADDR_MAIN_CTRL: r.mainCtrl = val[7:0]; // [R1]
         `ADDR_AUX_CTRL: begin
            r.auxCtrl = val[7:0]; // [R2]
            r.auxCtrl.auxReserved = 2'b00;
         end
         `ADDR_FILTER: r.filterWord = val[7:0]; // [R4]
         `ADDR_PORT_CTRL: r.portCtrl = val[15:0] & ~`PORT_CTRL_RESERVED_MASK; // [R3]
         `ADDR_MAIN_OFFSET: r.mainOffset[p] = val; // [R9]
         `ADDR_MAIN_GAIN: r.mainGain[p] = val; // [R11]
         `ADDR_AUX_OFFSET: r.auxOffset = val[15:0]; // [R12]
         `ADDR_AUX_GAIN: r.auxGain = val[15:0]; // [R13]
         `ADDR_TEST_ONE: r.testOne = val[15:0];
         `ADDR_TEST_TWO: r.testTwo = val[15:0];
         default: r = st; // [R14]
      endcase
      return r;
   endfunction

   always_comb begin
      logic [7:0] cmd;
      logic [4:0] nextCount;
      cmd = '0;
      nextCount = s_q.bitCount + 5'd1;
      s_d = s_q;

      // Fresh conversion results overwrite the previous ones.
      if (mainResultValid) begin
         s_d.mainResult = mainResultIn; // [R6]
      end
      if (auxResultValid) begin
         s_d.auxResult = auxResultIn; // [R7]
      end

      if (ev.selected && ev.rise) begin
         s_d.onesCount = ev.dataBit ? s_q.onesCount + 6'd1 : 6'd0;
         if (ev.dataBit && (s_q.onesCount + 6'd1 == `ONES_RESET_COUNT)) begin
            // A long run of ones recovers a lost sequence by a full bank reset.
            s_d = powerOnState(); // [R18]
         end else begin
            case (s_q.phase)
               PHASE_COMMAND: begin
                  // A high first bit is not a command; the port keeps waiting.
                  if (!(s_q.bitCount == 5'd0 && ev.dataBit)) begin // [R16]
                     s_d.inShift = {s_q.inShift[22:0], ev.dataBit};
                     s_d.bitCount = nextCount;
                     if (nextCount == `CMD_LENGTH) begin
                        cmd = {s_q.inShift[6:0], ev.dataBit};
                        s_d.bitCount = 5'd0;
                        s_d.isRead = cmd[`CMD_READ_BIT]; // [R16]
                        s_d.addr = cmd[`CMD_ADDR_MSB:`CMD_ADDR_LSB]; // [R17]
                        s_d.dataWidth = regWidth(cmd[`CMD_ADDR_MSB:`CMD_ADDR_LSB],
                                                 s_q.mainCtrl.resultLengthSelect);
                        s_d.outShift = readAligned(s_q, cmd[`CMD_ADDR_MSB:`CMD_ADDR_LSB],
                                                   statusByte);
                        // A write aimed at address zero is simply another command.
                        if (cmd[`CMD_READ_BIT] ||
                            cmd[`CMD_ADDR_MSB:`CMD_ADDR_LSB] != `ADDR_COMMAND_STATUS) begin
                           s_d.phase = PHASE_DATA;
                        end
                     end
                  end
               end
               PHASE_DATA: begin
                  s_d.inShift = {s_q.inShift[22:0], ev.dataBit};
                  s_d.bitCount = nextCount;
                  if (nextCount == s_q.dataWidth) begin
                     if (!s_q.isRead) begin
                        s_d = commitWrite(s_q, {s_q.inShift[22:0], ev.dataBit});
                        s_d.onesCount = ev.dataBit ? s_q.onesCount + 6'd1 : 6'd0;
                        if (mainResultValid) begin
                           s_d.mainResult = mainResultIn;
                        end
                        if (auxResultValid) begin
                           s_d.auxResult = auxResultIn;
                        end
                     end
                     s_d.bitCount = 5'd0;
                     s_d.phase = PHASE_COMMAND; // [R16]
                  end
               end
               default: begin
                  s_d.phase = PHASE_COMMAND;
               end
            endcase
         end
      end

      // Read data moves on the falling serial clock so it is stable at the rise.
      if (ev.selected && ev.fall && s_q.phase == PHASE_DATA && s_q.isRead) begin
         s_d.outShift = {s_q.outShift[22:0], 1'b0};
      end

      // Coefficients for the selected channel pair are presented to the datapath.
      s_d.mainOffsetSel = s_d.mainOffset[pairIndex(s_d.mainCtrl.mainPairSelect)]; // [R9]
      s_d.mainGainSel = s_d.mainGain[pairIndex(s_d.mainCtrl.mainPairSelect)]; // [R11]
      s_d.dout = s_d.outShift[23];
      s_d.doutOeN = ~(ev.selected && s_d.phase == PHASE_DATA && s_d.isRead);
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q <= powerOnState(); // [R18]
      end else begin
         s_q <= s_d;
      end
   end

   always_comb begin
      serialDataOut = s_q.dout;
      serialDataOutOeN = s_q.doutOeN;
      modeWord = s_q.mode;
      mainCtrl = s_q.mainCtrl;
      auxCtrl = s_q.auxCtrl;
      portCtrl = s_q.portCtrl;
      updateRateWord = s_q.filterWord; // [R5]
      mainOffsetActive = s_q.mainOffsetSel;
      mainGainActive = s_q.mainGainSel;
      auxOffset = s_q.auxOffset;
      auxGain = s_q.auxGain;
      testOne = s_q.testOne;
      testTwo = s_q.testTwo;
   end

endmodule

/* File: dual_adc_regs_chk.sv */
`timescale 1ns/1ps

module dual_adc_regs_chk
   import dual_adc_regs_pkg::*;
#(
   parameter logic [23:0] MAIN_GAIN_FACTORY = 24'h500005,
   parameter logic [7:0] AUX_GAIN_FACTORY_LOW = 8'h00
)
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic chipSelectN,
   input wire logic serialClk,
   input wire logic serialDataOut,
   input wire logic serialDataOutOeN,
   input main_ctrl_t mainCtrl,
   input aux_ctrl_t auxCtrl,
   input port_ctrl_t portCtrl,
   input wire logic [7:0] updateRateWord,
   input wire logic [23:0] mainOffsetActive,
   input wire logic [23:0] mainGainActive,
   input wire logic [15:0] auxOffset,
   input wire logic [15:0] auxGain
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   chk_oe_deselected: assert property (chipSelectN [*6] |-> serialDataOutOeN)
      else $error("data out driven while deselected");
   chk_dout_holds: assert property (
      (serialClk && !serialDataOutOeN) [*4] |-> $stable(serialDataOut))
      else $error("read bit changed while serial clock high");
   chk_aux_reserved: assert property (auxCtrl.auxReserved == 2'b00)
      else $error("aux control reserved bits set");
   chk_port_reserved: assert property (portCtrl.portReserved == 1'b0)
      else $error("port control reserved bit set");
   chk_reset_config: assert property (
      $rose(reset_n) |-> mainCtrl == 8'h07 && auxCtrl == 8'h01 &&
      portCtrl == 16'h0000 && updateRateWord == 8'h45)
      else $error("control values wrong after reset");
   chk_reset_coefs: assert property (
      $rose(reset_n) |-> mainOffsetActive == 24'h800000 &&
      mainGainActive == MAIN_GAIN_FACTORY && auxOffset == 16'h8000 &&
      auxGain == {8'h59, AUX_GAIN_FACTORY_LOW})
      else $error("coefficients wrong after reset");
   chk_cfg_quiet: assert property (
      chipSelectN [*8] |=> $stable(mainCtrl) && $stable(auxCtrl) && $stable(portCtrl))
      else $error("control changed with no access");
   chk_rate_quiet: assert property (
      chipSelectN [*8] |=> $stable(updateRateWord) && $stable(auxOffset))
      else $error("rate word changed with no access");
endmodule

bind dual_adc_register_bank dual_adc_regs_chk #(
   .MAIN_GAIN_FACTORY(MAIN_GAIN_FACTORY),
   .AUX_GAIN_FACTORY_LOW(AUX_GAIN_FACTORY_LOW)
) chk (
   .ref_clk(ref_clk),
   .reset_n(reset_n),
   .chipSelectN(chipSelectN),
   .serialClk(serialClk),
   .serialDataOut(serialDataOut),
   .serialDataOutOeN(serialDataOutOeN),
   .mainCtrl(mainCtrl),
   .auxCtrl(auxCtrl),
   .portCtrl(portCtrl),
   .updateRateWord(updateRateWord),
   .mainOffsetActive(mainOffsetActive),
   .mainGainActive(mainGainActive),
   .auxOffset(auxOffset),
   .auxGain(auxGain)
);

/* File: host_serial_model.sv */
`timescale 1ns/1ps

module host_serial_model (
   input wire logic ref_clk,
   output logic chipSelectN,
   output logic serialClk,
   output logic serialDataIn,
   input wire logic serialDataOut
);
   initial begin
      chipSelectN = 1'b1;
      serialClk = 1'b1;
      serialDataIn = 1'b1;
   end

   // One selected frame, MSB first; each clock half lasts 8 cycles to cover the pin sampler.
   task automatic frame(input logic [31:0] tx, input int n, output logic [31:0] rx);
      rx = '0;
      @(posedge ref_clk) chipSelectN <= 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         repeat (8) @(posedge ref_clk);
         // The device moves read data on each fall, so the bit is taken just before it.
         rx = {rx[30:0], serialDataOut};
         serialClk <= 1'b0;
         serialDataIn <= tx[i];
         repeat (8) @(posedge ref_clk);
         serialClk <= 1'b1;
      end
      repeat (8) @(posedge ref_clk);
      chipSelectN <= 1'b1;
      serialDataIn <= ~serialDataIn;
      // A real gap between frames lets the deselected behaviour be watched.
      repeat (10) @(posedge ref_clk);
   endtask
endmodule

/* File: tb_top.sv */
`timescale 1ns/1ps

module tb_top
   import dual_adc_regs_pkg::*;
;
   // Arbitrary identification value.
   localparam logic [7:0] IDENT = 8'h3c;
   localparam logic [23:0] MGAIN = 24'h5abcd5;
   localparam logic [7:0] ALOW = 8'h3e;
   typedef struct {logic [3:0] a; int w; logic [23:0] rst, wr, exp;} row_t;
   row_t rows[14] = '{'{4'h5, 16, 0, 24'hffff, 0}, '{4'h6, 16, 0, 24'hffff, 0},
      '{4'h8, 24, 24'h800000, 24'h123456, 24'h123456}, '{4'h9, 16, 24'h8000, 24'habcd, 24'habcd},
      '{4'ha, 24, MGAIN, 24'h654321, 24'h654321}, '{4'hb, 16, {8'h59, ALOW}, 24'h1357, 24'h1357},
      '{4'hc, 16, 0, 0, 0}, '{4'hd, 16, 0, 0, 0}, '{4'hf, 8, IDENT, 24'hff, IDENT},
      '{4'h1, 8, 0, 24'h5a, 24'h5a}, '{4'h3, 8, 24'h01, 24'hff, 24'hf9},
      '{4'h4, 8, 24'h45, 24'h13, 24'h13}, '{4'h7, 16, 0, 24'hffff, 24'hdfff},
      '{4'h2, 8, 24'h07, 24'hc7, 24'hc7}};
   logic ref_clk, reset_n, chipSelectN, serialClk, serialDataIn, serialDataOut;
   logic serialDataOutOeN, mainResultValid, auxResultValid, doutLine;
   logic tick = 1'b0;
   logic [7:0] statusByte, modeWord, updateRateWord;
   logic [23:0] mainResultIn, mainOffsetActive, mainGainActive;
   logic [15:0] auxResultIn, auxOffset, auxGain, testOne, testTwo;
   logic [31:0] rx;
   main_ctrl_t mainCtrl;
   aux_ctrl_t auxCtrl;
   port_ctrl_t portCtrl;
   int numErrors = 0;
   int totalChecks = 0;

   dual_adc_register_bank #(.PART_IDENT(IDENT), .MAIN_GAIN_FACTORY(MGAIN),
      .AUX_GAIN_FACTORY_LOW(ALOW)) DUT (.ref_clk(ref_clk), .reset_n(reset_n),
      .chipSelectN(chipSelectN), .serialClk(serialClk), .serialDataIn(serialDataIn),
      .serialDataOut(serialDataOut), .serialDataOutOeN(serialDataOutOeN),
      .statusByte(statusByte), .mainResultValid(mainResultValid),
      .mainResultIn(mainResultIn), .auxResultValid(auxResultValid),
      .auxResultIn(auxResultIn), .modeWord(modeWord), .mainCtrl(mainCtrl),
      .auxCtrl(auxCtrl), .portCtrl(portCtrl), .updateRateWord(updateRateWord),
      .mainOffsetActive(mainOffsetActive), .mainGainActive(mainGainActive),
      .auxOffset(auxOffset), .auxGain(auxGain), .testOne(testOne), .testTwo(testTwo));
   host_serial_model host (.ref_clk(ref_clk), .chipSelectN(chipSelectN),
      .serialClk(serialClk), .serialDataIn(serialDataIn), .serialDataOut(doutLine));

   // A released data line shows a changing pattern, never a held value.
   assign doutLine = serialDataOutOeN ? tick : serialDataOut;
   always @(posedge ref_clk) tick <= ~tick;

   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   task automatic check(input string nm, input logic [23:0] e, input logic [23:0] g);
      totalChecks++;
      if (g !== e) begin
         numErrors++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask

   task automatic wrReg(input logic [3:0] a, input int w, input logic [23:0] d);
      logic [31:0] r;
      host.frame((32'({4'h0, a}) << w) | 32'(d), 8 + w, r);
   endtask

   task automatic rdCheck(input logic [3:0] a, input int w, input logic [23:0] e);
      logic [31:0] r;
      host.frame(32'({4'h4, a}) << w, 8 + w, r);
      check($sformatf("reg %h", a), e, r[23:0] & 24'((32'h1 << w) - 1));
   endtask

   task automatic completeRun();
      $display("checks %0d, mismatches %0d", totalChecks, numErrors);
      if (numErrors == 0 && totalChecks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      repeat (80000) @(posedge ref_clk);
      numErrors++;
      completeRun();
   end

   initial begin
      reset_n = 1'b0;
      statusByte = 8'h00;
      mainResultValid = 1'b0;
      auxResultValid = 1'b0;
      mainResultIn = '0;
      auxResultIn = '0;
      repeat (16) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      foreach (rows[i]) begin
         rdCheck(rows[i].a, rows[i].w, rows[i].rst);
         wrReg(rows[i].a, rows[i].w, rows[i].wr);
         rdCheck(rows[i].a, rows[i].w, rows[i].exp);
      end
      check("mode word", 24'h5a, modeWord);
      check("port control", 24'hdfff, portCtrl);
      check("aux control", 24'hf9, auxCtrl);
      check("aux offset", 24'habcd, auxOffset);
      check("aux gain", 24'h1357, auxGain);
      check("test one", 24'h0, testOne);
      check("test two", 24'h0, testTwo);
      $display("register table done");
      for (int p = 0; p < 3; p++) begin
         wrReg(4'h2, 8, 24'(8'hc7 | 8'(p << 4)));
         wrReg(4'h8, 24, 24'h100000 + 24'(p));
         wrReg(4'ha, 24, 24'h200000 + 24'(p));
      end
      for (int p = 0; p < 3; p++) begin
         wrReg(4'h2, 8, 24'(8'hc7 | 8'(p << 4)));
         check("offset active", 24'h100000 + 24'(p), mainOffsetActive);
         check("gain active", 24'h200000 + 24'(p), mainGainActive);
         rdCheck(4'h8, 24, 24'h100000 + 24'(p));
      end
      $display("channel pair coefficients done");
      @(posedge ref_clk);
      mainResultValid <= 1'b1;
      auxResultValid <= 1'b1;
      mainResultIn <= 24'habcdef;
      auxResultIn <= 16'h4321;
      statusByte <= 8'ha5;
      @(posedge ref_clk);
      mainResultValid <= 1'b0;
      auxResultValid <= 1'b0;
      rdCheck(4'h5, 24, 24'habcdef);
      rdCheck(4'h6, 16, 24'h4321);
      wrReg(4'h2, 8, 24'h87);
      check("main control", 24'h87, mainCtrl);
      rdCheck(4'h5, 16, 24'habcd);
      rdCheck(4'h0, 8, 24'ha5);
      $display("results done");
      host.frame(32'({2'b11, 8'h04, 8'h77}), 18, rx);
      check("rate word", 24'h77, updateRateWord);
      rdCheck(4'h4, 8, 24'h77);
      host.frame(32'({8'h00, 8'h04, 8'h5c}), 24, rx);
      check("rate word", 24'h5c, updateRateWord);
      $display("leading ones done");
      host.frame(32'hffffffff, 32, rx);
      check("rate word", 24'h45, updateRateWord);
      check("main control", 24'h07, mainCtrl);
      rdCheck(4'h8, 24, 24'h800000);
      $display("ones recovery done");
      wrReg(4'h4, 8, 24'h13);
      reset_n <= 1'b0;
      repeat (16) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      check("rate word", 24'h45, updateRateWord);
      check("aux gain", {8'h59, ALOW}, auxGain);
      check("gain active", MGAIN, mainGainActive);
      $display("mid-run reset done");
      completeRun();
   end
endmodule
